// ===== irq_enable_defines.svh
// Notes on behaviour
// - register decoded at address 0xE7 on every page, page select ignored.
// - bits 7 to 4 read zero; writes to them are dropped.
// - bit 3 gates all radio serial port interrupt requests.
// - bit 2 gates the clock oscillator-fail interrupt request.
// - bit 1 gates the port match event interrupt requests.
// - bit 0 gates the supply monitor early warning request.
`ifndef IRQ_ENABLE_DEFINES_SVH
`define IRQ_ENABLE_DEFINES_SVH
`define IES_ADDR        8'hE7
`define IES_RESET       4'h0
`define IES_USED_BITS   4
`define IES_BIT_WARN    0
`define IES_BIT_MATCH   1
`define IES_BIT_RTC     2
`define IES_BIT_RADIO   3
`endif

// ===== irq_enable_pkg.sv
package irq_enable_pkg;
    typedef logic [7:0] sfr_byte_t;
    typedef logic [3:0] enable_bits_t;
endpackage

// ===== irq_gate_if.sv
`timescale 1ns/100ps
interface irq_gate_if;
    logic [3:0] pending;
    logic [3:0] enable;
    logic [3:0] gated;
    modport gate (input pending, input enable, output gated);
    modport ctrl (output pending, output enable, input gated);
endinterface

// ===== irq_gate.sv
`timescale 1ns/100ps
`include "irq_enable_defines.svh"
module irq_gate (
    irq_gate_if.gate g
);
    genvar i;
    generate
        for (i = 0; i < `IES_USED_BITS; i = i + 1) begin : g_bit
            assign g.gated[i] = g.pending[i] & g.enable[i];
        end
    endgenerate
endmodule // irq_gate

// ===== extended_irq_enable_second.sv
`timescale 1ns/100ps
`include "irq_enable_defines.svh"
module extended_irq_enable_second
    import irq_enable_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       SYS_RST,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic [7:0] SFR_PAGE,
    output logic      [7:0] SFR_RDATA,
    output logic            SFR_HIT,
    input  wire logic       RADIO_SERIAL_PEND,
    input  wire logic       RTC_OSC_FAIL_PEND,
    input  wire logic       PORT_MATCH_PEND,
    input  wire logic       SUPPLY_WARNING_PEND,
    output logic            RADIO_SERIAL_IRQ,
    output logic            RTC_OSC_FAIL_IRQ,
    output logic            PORT_MATCH_IRQ,
    output logic            SUPPLY_WARNING_IRQ
);
    // ****************************************
    // decode
    // ****************************************
    enable_bits_t interrupt_enable_second;
    wire          sel;
    wire          wr_hit;
    wire          rd_hit;
    wire    [3:0] write_bits;
    wire    [3:0] next_enable;
    wire    [7:0] read_word;
    wire    [7:0] next_rdata;

    assign sel         = (SFR_ADDR == `IES_ADDR);
    assign wr_hit      = sel & SFR_WR;
    assign rd_hit      = sel & SFR_RD;
    assign SFR_HIT     = sel;

    a_hit_decode: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        SFR_HIT == (SFR_ADDR == `IES_ADDR)
    ) else $error("hit flag does not follow the address");

    a_any_page_write: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (wr_hit && (SFR_PAGE != 8'h00))
        |=> interrupt_enable_second == $past(SFR_WDATA[3:0])
    ) else $error("write on a nonzero page not stored");

    a_miss_write_hold: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (SFR_WR && !sel)
        |=> $stable(interrupt_enable_second)
    ) else $error("write to another address changed the enables");

    // ****************************************
    // register
    // ****************************************
    // upper write bits dropped
    assign write_bits  = SFR_WDATA[3:0];
    assign next_enable = wr_hit ? write_bits : interrupt_enable_second;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            interrupt_enable_second <= `IES_RESET;
        end else begin
            interrupt_enable_second <= next_enable;
        end
    end

    a_write_takes: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        wr_hit
        |=> interrupt_enable_second == $past(SFR_WDATA[3:0])
    ) else $error("write at enable address not stored");

    a_other_addr_hold: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !wr_hit
        |=> $stable(interrupt_enable_second)
    ) else $error("enable changed without write");

    a_upper_write_drop: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (wr_hit && (SFR_WDATA[7:4] != 4'h0))
        |=> interrupt_enable_second == $past(SFR_WDATA[3:0])
    ) else $error("upper write bits leaked into the enables");

    a_reset_clear: assert property (
        @(posedge CLK_SYS)
        SYS_RST
        |=> (interrupt_enable_second == `IES_RESET) && (SFR_RDATA == 8'h00)
    ) else $error("enable or read data not cleared by reset");

    a_release_clear: assert property (
        @(posedge CLK_SYS)
        $fell(SYS_RST)
        |-> interrupt_enable_second == `IES_RESET
    ) else $error("enables not clear after reset release");

    // ****************************************
    // read path
    // ****************************************
    // upper read bits zero
    assign read_word   = {4'h0, interrupt_enable_second};
    assign next_rdata  = rd_hit ? read_word : 8'h00;

    // a read in a write cycle returns the value held before the write
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            SFR_RDATA <= 8'h00;
        end else begin
            SFR_RDATA <= next_rdata;
        end
    end

    a_upper_read_zero: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        SFR_RDATA[7:4] == 4'h0
    ) else $error("upper read bits not zero");

    a_read_value: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (rd_hit && !SFR_WR)
        |=> SFR_RDATA[3:0] == $past(interrupt_enable_second)
    ) else $error("read data mismatch");

    a_read_in_write: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (rd_hit && wr_hit)
        |=> SFR_RDATA == {4'h0, $past(interrupt_enable_second)}
    ) else $error("read in a write cycle did not return the old value");

    a_read_idle_zero: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !rd_hit
        |=> SFR_RDATA == 8'h00
    ) else $error("read data not zero without a read of the enables");

    // ****************************************
    // gating
    // ****************************************
    irq_gate_if gif ();
    assign gif.pending = {RADIO_SERIAL_PEND, RTC_OSC_FAIL_PEND,
                          PORT_MATCH_PEND, SUPPLY_WARNING_PEND};
    assign gif.enable  = interrupt_enable_second;
    irq_gate u_gate (.g(gif));

    assign RADIO_SERIAL_IRQ = gif.gated[`IES_BIT_RADIO];
    assign RTC_OSC_FAIL_IRQ = gif.gated[`IES_BIT_RTC];
    assign PORT_MATCH_IRQ = gif.gated[`IES_BIT_MATCH];
    assign SUPPLY_WARNING_IRQ = gif.gated[`IES_BIT_WARN];

    a_radio_gate: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        RADIO_SERIAL_IRQ == (RADIO_SERIAL_PEND & interrupt_enable_second[3])
    ) else $error("radio gate wrong");

    a_rtc_gate: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        RTC_OSC_FAIL_IRQ == (RTC_OSC_FAIL_PEND & interrupt_enable_second[2])
    ) else $error("rtc gate wrong");

    a_match_gate: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        PORT_MATCH_IRQ == (PORT_MATCH_PEND & interrupt_enable_second[1])
    ) else $error("match gate wrong");

    a_warn_gate: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        SUPPLY_WARNING_IRQ == (SUPPLY_WARNING_PEND & interrupt_enable_second[0])
    ) else $error("warning gate wrong");

    a_radio_blocked: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !interrupt_enable_second[`IES_BIT_RADIO]
        |-> !RADIO_SERIAL_IRQ
    ) else $error("radio request passed while disabled");

    a_rtc_blocked: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !interrupt_enable_second[`IES_BIT_RTC]
        |-> !RTC_OSC_FAIL_IRQ
    ) else $error("oscillator fail request passed while disabled");

    a_match_blocked: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !interrupt_enable_second[`IES_BIT_MATCH]
        |-> !PORT_MATCH_IRQ
    ) else $error("port match request passed while disabled");

    a_warn_blocked: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !interrupt_enable_second[`IES_BIT_WARN]
        |-> !SUPPLY_WARNING_IRQ
    ) else $error("supply warning request passed while disabled");

    a_gate_and: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        gif.gated == (gif.pending & gif.enable)
    ) else $error("gated requests differ from flag and enable");

    a_irq_needs_pend: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        ({RADIO_SERIAL_IRQ, RTC_OSC_FAIL_IRQ, PORT_MATCH_IRQ, SUPPLY_WARNING_IRQ}
            & ~gif.pending) == 4'h0
    ) else $error("request raised without a pending flag");
endmodule // extended_irq_enable_second

// ===== irq_core_model.sv
`timescale 1ns/100ps
module irq_core_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] irq,
    output logic      [3:0] seen
);
    // core polls requests once a clock; a missed gate shows one cycle late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) seen <= 4'h0;
        else seen <= irq;
    end
endmodule // irq_core_model

// ===== extended_irq_enable_second_tb.sv
`timescale 1ns/100ps
module extended_irq_enable_second_tb;
    import irq_enable_pkg::*;
    logic       clk       = 1'h0;
    logic       rst       = 1'h1;
    logic       wr        = 1'h0;
    logic       rd        = 1'h0;
    logic       hit;
    sfr_byte_t  addr      = 8'h00;
    sfr_byte_t  wdata     = 8'h00;
    sfr_byte_t  page      = 8'h00;
    sfr_byte_t  rdata;
    sfr_byte_t  v         = 8'h00;
    logic [3:0] pend      = 4'h0;
    wire  [3:0] irq;
    wire  [3:0] seen;
    int         err_count = 0;
    int         cmp_count = 0;
    always #12.5 clk = ~clk;
    extended_irq_enable_second extended_irq_enable_second_i (.CLK_SYS(clk), .SYS_RST(rst),
        .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_PAGE(page),
        .SFR_RDATA(rdata), .SFR_HIT(hit), .RADIO_SERIAL_PEND(pend[3]),
        .RTC_OSC_FAIL_PEND(pend[2]), .PORT_MATCH_PEND(pend[1]), .SUPPLY_WARNING_PEND(pend[0]),
        .RADIO_SERIAL_IRQ(irq[3]), .RTC_OSC_FAIL_IRQ(irq[2]), .PORT_MATCH_IRQ(irq[1]),
        .SUPPLY_WARNING_IRQ(irq[0]));
    irq_core_model irq_core_model_i (.clk(clk), .rst(rst), .irq(irq), .seen(seen));
    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic sfr_wr(sfr_byte_t a, sfr_byte_t d, sfr_byte_t p);
        @(negedge clk);
        addr  = a;
        wdata = d;
        page  = p;
        wr    = 1'h1;
        @(negedge clk);
        wr    = 1'h0;
    endtask
    // read data is registered, so it is taken one edge after the strobe
    task automatic sfr_rd(sfr_byte_t a);
        @(negedge clk);
        addr = a;
        rd   = 1'h1;
        @(negedge clk);
        rd   = 1'h0;
        v    = rdata;
    endtask
    task automatic t_reset;
        pend = 4'hF;
        sfr_rd(8'hE7);
        check("reset_read", 8'h00, v);
        check("reset_irq", 8'h00, {4'h0, irq});
        check("reset_seen", 8'h00, {4'h0, seen});
        pend = 4'h0;
    endtask
    task automatic t_access;
        sfr_wr(8'hE7, 8'hFF, 8'h0F);
        sfr_rd(8'hE7);
        check("upper_bits", 8'h0F, v);
        check("hit", 8'h01, {7'h0, hit});
        @(negedge clk);
        check("read_drop", 8'h00, rdata);
        sfr_wr(8'hE6, 8'h00, 8'h00);
        sfr_rd(8'hE7);
        check("other_addr", 8'h0F, v);
        sfr_rd(8'hE6);
        check("other_read", 8'h00, v);
        check("miss_hit", 8'h00, {7'h0, hit});
        @(negedge clk);
        addr  = 8'hE7;
        wdata = 8'h03;
        wr    = 1'h1;
        rd    = 1'h1;
        @(negedge clk);
        wr    = 1'h0;
        rd    = 1'h0;
        check("read_in_write", 8'h0F, rdata);
        sfr_rd(8'hE7);
        check("after_rw", 8'h03, v);
    endtask
    task automatic t_gate;
        for (int b = 0; b < 4; b++) begin
            sfr_wr(8'hE7, 8'h01 << b, 8'(b));
            pend = 4'hF;
            @(negedge clk);
            check("gate", 8'h01 << b, {4'h0, irq});
            check("core_seen", 8'h01 << b, {4'h0, seen});
            pend = 4'h0;
            @(negedge clk);
            check("pend_low", 8'h00, {4'h0, irq});
        end
        sfr_wr(8'hE7, 8'h0F, 8'hFF);
        pend = 4'h5;
        @(negedge clk);
        check("mixed_lo", 8'h05, {4'h0, irq});
        pend = 4'hA;
        @(negedge clk);
        check("mixed_hi", 8'h0A, {4'h0, irq});
        check("core_mixed", 8'h0A, {4'h0, seen});
        pend = 4'h0;
    endtask
    task automatic t_midreset;
        sfr_wr(8'hE7, 8'h0F, 8'h00);
        pend = 4'hF;
        @(negedge clk);
        check("pre_reset_irq", 8'h0F, {4'h0, irq});
        rst = 1'h1;
        #1;
        check("async_clear", 8'h00, {4'h0, irq});
        @(negedge clk);
        check("reset_rdata", 8'h00, rdata);
        rst = 1'h0;
        sfr_rd(8'hE7);
        check("after_reset", 8'h00, v);
        check("after_irq", 8'h00, {4'h0, irq});
        pend = 4'h0;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // tests need well under a hundred cycles, so 500 only trips on a hang
    initial begin
        #(25 * 500);
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'h0;
        t_reset();
        t_access();
        t_gate();
        t_midreset();
        wrap_up();
    end
endmodule // extended_irq_enable_second_tb
